// ---- rtl/spp_unit.sv ----
// Pack and condition-select execution unit for the signal extension.
// Assumes the pipeline presents one instruction with both sources and
// the control register in the issue cycle; the result follows one
// clock-enabled edge later.
`timescale 1ns/100ps
module spp_unit
   import spp_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic issue_in,
   input wire logic [INSTR_W-1:0] instr_in,
   input wire logic [DATA_W-1:0] first_source_in,
   input wire logic [DATA_W-1:0] second_source_in,
   input wire logic [CTRL_W-1:0] signal_ext_control_reg_in,
   input wire logic ext_enable_in,
   output logic [IDX_W-1:0] first_source_idx_out,
   output logic [IDX_W-1:0] second_source_idx_out,
   output logic wr_en_out,
   output logic [IDX_W-1:0] dest_idx_out,
   output logic [DATA_W-1:0] dest_data_out,
   output spp_op_t op_out,
   output logic reserved_exc_out,
   output logic disabled_exc_out
);

   // ------
   // State
   // ------
   typedef struct packed {
      logic wr_en;
      logic [IDX_W-1:0] dest;
      logic [DATA_W-1:0] data;
      spp_op_t op;
      logic rsv_exc;
      logic dis_exc;
   } spp_state_t;

   spp_state_t st_r;
   spp_state_t st_nxt;

   spp_op_t dec_op;
   logic [IDX_W-1:0] dec_dest;
   logic [COND_W-1:0] compare_condition_bits;
   logic [COND_W-1:0] lane_sel;
   logic [DATA_W-1:0] picked;
   logic [DATA_W-1:0] result;

   // ------
   // Decode and lane selection
   // ------

   // Source register indices go to the register file straight from the decoder; the destination index is registered.
   spp_decode u_decode (
      .instr_in(instr_in),
      .op_out(dec_op),
      .first_source_idx_out(first_source_idx_out),
      .second_source_idx_out(second_source_idx_out),
      .dest_idx_out(dec_dest)
   );

   // The condition field is only read here; nothing drives it back.
   assign compare_condition_bits = signal_ext_control_reg_in[COND_LO +: COND_W];

   // One byte-lane selector serves every select width: wider lanes just
   // repeat their condition bit over the bytes they cover.
   always_comb begin
      case (dec_op)
         SPP_OP_SELECT_EIGHT_BYTES: begin
            lane_sel = compare_condition_bits;
         end
         SPP_OP_SELECT_FOUR_BYTES: begin
            lane_sel = {4'h0, compare_condition_bits[3:0]};
         end
         SPP_OP_SELECT_TWO_HALFWORDS: begin
            lane_sel = {4'h0, {2{compare_condition_bits[1]}},
                        {2{compare_condition_bits[0]}}};
         end
         SPP_OP_SELECT_TWO_WORDS: begin
            lane_sel = {{4{compare_condition_bits[1]}},
                        {4{compare_condition_bits[0]}}};
         end
         default: begin
            lane_sel = 8'h00;
         end
      endcase
   end

   spp_lane_pick #(
      .LANES(COND_W),
      .LANE_W(8)
   ) u_pick (
      .first_in(first_source_in),
      .second_in(second_source_in),
      .sel_in(lane_sel),
      .pick_out(picked)
   );

   // ------
   // Result formation
   // ------

   // No arithmetic is done, so no operand value can raise an exception.
   always_comb begin
      case (dec_op)
         SPP_OP_PACK_CROSS_HALFWORDS: begin
            result = {{32{first_source_in[15]}}, first_source_in[15:0],
                      second_source_in[31:16]};
         end
         SPP_OP_PACK_CROSS_WORDS: begin
            result = {first_source_in[31:0], second_source_in[63:32]};
         end
         SPP_OP_SELECT_EIGHT_BYTES, SPP_OP_SELECT_TWO_WORDS: begin
            result = picked;
         end
         SPP_OP_SELECT_TWO_HALFWORDS, SPP_OP_SELECT_FOUR_BYTES: begin
            result = {{32{picked[31]}}, picked[31:0]};
         end
         default: begin
            result = RESULT_RST;
         end
      endcase
   end

   // ------
   // Next state and register
   // ------

   // Exceptions depend only on the encoding and the enable, never on data.
   always_comb begin
      st_nxt = st_r;
      if (ce_in) begin
         st_nxt.wr_en = 1'b0;
         st_nxt.rsv_exc = 1'b0;
         st_nxt.dis_exc = 1'b0;
         if (issue_in) begin
            st_nxt.op = dec_op;
            st_nxt.dest = dec_dest;
            if (dec_op == SPP_OP_NONE) begin
               st_nxt.rsv_exc = 1'b1;
            end else if (!ext_enable_in) begin
               st_nxt.dis_exc = 1'b1;
            end else begin
               st_nxt.wr_en = 1'b1;
               st_nxt.data = result;
            end
         end
      end
   end

   // Low clock enable holds every bit, including the one-cycle pulses.
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         st_r <= '{wr_en: 1'b0, dest: IDX_RST, data: RESULT_RST,
                   op: SPP_OP_NONE, rsv_exc: 1'b0, dis_exc: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign wr_en_out = st_r.wr_en;
   assign dest_idx_out = st_r.dest;
   assign dest_data_out = st_r.data;
   assign op_out = st_r.op;
   assign reserved_exc_out = st_r.rsv_exc;
   assign disabled_exc_out = st_r.dis_exc;

   // ------
   // Checks
   // ------
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   logic go;
   assign go = ce_in && issue_in && ext_enable_in;

   // Byte mask built from condition bits 27..24 alone, apart from the datapath.
   logic [31:0] sel4_mask;
   assign sel4_mask = {{8{signal_ext_control_reg_in[27]}}, {8{signal_ext_control_reg_in[26]}},
                       {8{signal_ext_control_reg_in[25]}}, {8{signal_ext_control_reg_in[24]}}};

   pack_half_dec_a: assert property (
      go && instr_in[31:26] == 6'h1F && instr_in[10:6] == 5'h0E
         && instr_in[5:0] == 6'h11
      |=> wr_en_out && op_out == SPP_OP_PACK_CROSS_HALFWORDS
         && dest_idx_out == $past(instr_in[15:11]))
      else $error("Halfword pack not decoded.");

   pack_word_dec_a: assert property (
      go && instr_in[31:26] == 6'h1F && instr_in[10:6] == 5'h0E
         && instr_in[5:0] == 6'h15
      |=> wr_en_out && op_out == SPP_OP_PACK_CROSS_WORDS)
      else $error("Word pack not decoded.");

   sel8_dec_a: assert property (
      go && instr_in[31:26] == 6'h1F && instr_in[10:6] == 5'h03
         && instr_in[5:0] == 6'h15
      |=> op_out == SPP_OP_SELECT_EIGHT_BYTES)
      else $error("Eight-byte select not decoded.");

   sel2h_dec_a: assert property (
      go && instr_in[31:26] == 6'h1F && instr_in[10:6] == 5'h0B
         && instr_in[5:0] == 6'h11
      |=> op_out == SPP_OP_SELECT_TWO_HALFWORDS)
      else $error("Two-halfword select not decoded.");

   sel2w_dec_a: assert property (
      go && instr_in[31:26] == 6'h1F && instr_in[10:6] == 5'h13
         && instr_in[5:0] == 6'h15
      |=> op_out == SPP_OP_SELECT_TWO_WORDS)
      else $error("Two-word select not decoded.");

   sel4_dec_a: assert property (
      go && instr_in[31:26] == 6'h1F && instr_in[10:6] == 5'h03
         && instr_in[5:0] == 6'h11
      |=> op_out == SPP_OP_SELECT_FOUR_BYTES)
      else $error("Four-byte select not decoded.");

   pack_half_data_a: assert property (
      go && dec_op == SPP_OP_PACK_CROSS_HALFWORDS
      |=> dest_data_out[31:16] == $past(first_source_in[15:0])
         && dest_data_out[15:0] == $past(second_source_in[31:16]))
      else $error("Halfword pack lanes wrong.");

   pack_half_sext_a: assert property (
      wr_en_out && op_out == SPP_OP_PACK_CROSS_HALFWORDS
      |-> dest_data_out[63:32] == {32{dest_data_out[31]}})
      else $error("Halfword pack not sign-extended.");

   pack_word_data_a: assert property (
      go && dec_op == SPP_OP_PACK_CROSS_WORDS
      |=> dest_data_out == {$past(first_source_in[31:0]),
                            $past(second_source_in[63:32])})
      else $error("Word pack lanes wrong.");

   for (genvar i = 0; i < 8; i++) begin : g_chk
      sel8_lane_a: assert property (
         go && dec_op == SPP_OP_SELECT_EIGHT_BYTES
         |=> dest_data_out[i*8 +: 8] == ($past(signal_ext_control_reg_in[24+i])
            ? $past(first_source_in[i*8 +: 8]) : $past(second_source_in[i*8 +: 8])))
         else $error("Eight-byte select lane wrong.");
   end

   sel2h_data_a: assert property (
      go && dec_op == SPP_OP_SELECT_TWO_HALFWORDS
         && signal_ext_control_reg_in[25:24] == 2'h2
      |=> dest_data_out[31:0] == {$past(first_source_in[31:16]),
                                  $past(second_source_in[15:0])})
      else $error("Two-halfword select lanes wrong.");

   sel2h_sext_a: assert property (
      wr_en_out && op_out == SPP_OP_SELECT_TWO_HALFWORDS
      |-> dest_data_out[63:32] == {32{dest_data_out[31]}})
      else $error("Two-halfword select not sign-extended.");

   sel2w_data_a: assert property (
      go && dec_op == SPP_OP_SELECT_TWO_WORDS
         && signal_ext_control_reg_in[25:24] == 2'h1
      |=> dest_data_out == {$past(second_source_in[63:32]),
                            $past(first_source_in[31:0])})
      else $error("Two-word select words wrong.");

   sel4_data_a: assert property (
      go && dec_op == SPP_OP_SELECT_FOUR_BYTES
      |=> dest_data_out[31:0] == $past((first_source_in[31:0] & sel4_mask)
         | (second_source_in[31:0] & ~sel4_mask)))
      else $error("Four-byte select bytes wrong.");

   sel4_sext_a: assert property (
      wr_en_out && op_out == SPP_OP_SELECT_FOUR_BYTES
      |-> dest_data_out[63:32] == {32{dest_data_out[31]}})
      else $error("Four-byte select not sign-extended.");

   exc_cause_a: assert property (
      ce_in && issue_in
      |=> reserved_exc_out == ($past(dec_op) == SPP_OP_NONE)
         && disabled_exc_out == ($past(dec_op) != SPP_OP_NONE && !$past(ext_enable_in))
         && !(wr_en_out && (reserved_exc_out || disabled_exc_out)))
      else $error("Exception not tied to encoding and enable.");

   one_cycle_a: assert property (
      ce_in && !issue_in |=> !wr_en_out && !reserved_exc_out && !disabled_exc_out)
      else $error("Pulse outlived its issue.");

   freeze_hold_a: assert property (
      !ce_in |=> $stable(st_r))
      else $error("State moved with clock enable low.");

   // ------
   // Lane, answer and reset checks
   // ------

   // The fixed-pattern checks above see one condition value each; these
   // follow whatever pattern the pipeline presents.
   sel2h_lane_a: assert property (
      go && dec_op == SPP_OP_SELECT_TWO_HALFWORDS
      |=> dest_data_out[31:16] == ($past(signal_ext_control_reg_in[25])
            ? $past(first_source_in[31:16]) : $past(second_source_in[31:16]))
         && dest_data_out[15:0] == ($past(signal_ext_control_reg_in[24])
            ? $past(first_source_in[15:0]) : $past(second_source_in[15:0])))
      else $error("Two-halfword select half wrong.");

   // Each word follows its own condition bit, bit 25 the high word.
   sel2w_lane_a: assert property (
      go && dec_op == SPP_OP_SELECT_TWO_WORDS
      |=> dest_data_out[63:32] == ($past(signal_ext_control_reg_in[25])
            ? $past(first_source_in[63:32]) : $past(second_source_in[63:32]))
         && dest_data_out[31:0] == ($past(signal_ext_control_reg_in[24])
            ? $past(first_source_in[31:0]) : $past(second_source_in[31:0])))
      else $error("Two-word select word wrong.");

   // Index fields reach the register file unregistered, in the issue cycle.
   src_idx_a: assert property (
      first_source_idx_out == instr_in[25:21] && second_source_idx_out == instr_in[20:16])
      else $error("Source index fields wrong.");

   // A refused or absent issue must leave the held result alone.
   data_hold_a: assert property (
      !(ce_in && issue_in && dec_op != SPP_OP_NONE && ext_enable_in)
      |=> $stable(dest_data_out))
      else $error("Result changed without a write.");

   // Every taken issue is answered by exactly one of write, reserved or disabled.
   one_answer_a: assert property (
      ce_in && issue_in |=> $onehot({wr_en_out, reserved_exc_out, disabled_exc_out}))
      else $error("Issue answered other than once.");

   // This one checks reset itself, so reset must not switch it off.
   reset_val_a: assert property (@(posedge core_clk_in) disable iff (1'b0)
      !rst_n_in |=> !wr_en_out && !reserved_exc_out && !disabled_exc_out
         && dest_data_out == RESULT_RST && dest_idx_out == IDX_RST
         && op_out == SPP_OP_NONE)
      else $error("Outputs not cleared by reset.");

   pack_half_c: cover property (go && dec_op == SPP_OP_PACK_CROSS_HALFWORDS);
   sel8_c: cover property (go && dec_op == SPP_OP_SELECT_EIGHT_BYTES);
   sel2w_c: cover property (go && dec_op == SPP_OP_SELECT_TWO_WORDS);
   disabled_c: cover property (disabled_exc_out);
   reserved_c: cover property (reserved_exc_out);

endmodule : spp_unit

// ---- rtl/spp_pkg.sv ----
// Shared constants, field layout and decode helper for the pack/select unit.
// Assumes a 32-bit instruction word and 64-bit general registers.
package spp_pkg;

   // ------
   // Widths and instruction fields
   // ------
   localparam int unsigned INSTR_W = 32;
   localparam int unsigned DATA_W = 64;
   localparam int unsigned CTRL_W = 32;
   localparam int unsigned IDX_W = 5;
   localparam int unsigned OPC_LO = 26;
   localparam int unsigned SRCA_LO = 21;
   localparam int unsigned SRCB_LO = 16;
   localparam int unsigned DST_LO = 11;
   localparam int unsigned SUB_LO = 6;
   localparam int unsigned FN_LO = 0;

   // ------
   // Encodings
   // ------
   localparam logic [5:0] OPC_MAJOR_GROUP_THREE = 6'h1F;
   localparam logic [4:0] SUB_PACK_CROSS = 5'h0E;
   localparam logic [4:0] SUB_SELECT_BYTES = 5'h03;
   localparam logic [4:0] SUB_SELECT_HALVES = 5'h0B;
   localparam logic [4:0] SUB_SELECT_WORDS = 5'h13;
   localparam logic [5:0] FN_GROUP_QUAD_BYTE = 6'h11;
   localparam logic [5:0] FN_GROUP_OCTAL_BYTE = 6'h15;

   // Condition bits live in the control register from this bit upward.
   localparam int unsigned COND_LO = 24;
   localparam int unsigned COND_W = 8;
   localparam logic [DATA_W-1:0] RESULT_RST = 64'h0000_0000_0000_0000;
   localparam logic [IDX_W-1:0] IDX_RST = 5'h00;

   typedef enum logic [2:0] {
      SPP_OP_NONE,
      SPP_OP_PACK_CROSS_HALFWORDS,
      SPP_OP_PACK_CROSS_WORDS,
      SPP_OP_SELECT_EIGHT_BYTES,
      SPP_OP_SELECT_TWO_HALFWORDS,
      SPP_OP_SELECT_TWO_WORDS,
      SPP_OP_SELECT_FOUR_BYTES
   } spp_op_t;

   // Maps an instruction word to the operation it names.
   function automatic spp_op_t spp_decode_op(input logic [INSTR_W-1:0] instr);
      logic [5:0] opc;
      logic [4:0] sub;
      logic [5:0] fn;
      opc = instr[OPC_LO +: 6];
      sub = instr[SUB_LO +: 5];
      fn = instr[FN_LO +: 6];
      spp_decode_op = SPP_OP_NONE;
      if (opc == OPC_MAJOR_GROUP_THREE) begin
         case ({sub, fn})
            {SUB_PACK_CROSS, FN_GROUP_QUAD_BYTE}: spp_decode_op = SPP_OP_PACK_CROSS_HALFWORDS;
            {SUB_PACK_CROSS, FN_GROUP_OCTAL_BYTE}: spp_decode_op = SPP_OP_PACK_CROSS_WORDS;
            {SUB_SELECT_BYTES, FN_GROUP_OCTAL_BYTE}: spp_decode_op = SPP_OP_SELECT_EIGHT_BYTES;
            {SUB_SELECT_HALVES, FN_GROUP_QUAD_BYTE}: spp_decode_op = SPP_OP_SELECT_TWO_HALFWORDS;
            {SUB_SELECT_WORDS, FN_GROUP_OCTAL_BYTE}: spp_decode_op = SPP_OP_SELECT_TWO_WORDS;
            {SUB_SELECT_BYTES, FN_GROUP_QUAD_BYTE}: spp_decode_op = SPP_OP_SELECT_FOUR_BYTES;
            default: spp_decode_op = SPP_OP_NONE;
         endcase
      end
   endfunction : spp_decode_op

endpackage : spp_pkg

// ---- rtl/spp_decode.sv ----
// Instruction field decoder for the pack/select unit.
// Assumes a whole instruction word is presented; purely combinational.
`timescale 1ns/100ps
module spp_decode
   import spp_pkg::*;
(
   input wire logic [INSTR_W-1:0] instr_in,
   output spp_op_t op_out,
   output logic [IDX_W-1:0] first_source_idx_out,
   output logic [IDX_W-1:0] second_source_idx_out,
   output logic [IDX_W-1:0] dest_idx_out
);

   // Operation and register index fields.
   assign op_out = spp_decode_op(instr_in);
   assign first_source_idx_out = instr_in[SRCA_LO +: IDX_W];
   assign second_source_idx_out = instr_in[SRCB_LO +: IDX_W];
   assign dest_idx_out = instr_in[DST_LO +: IDX_W];

endmodule : spp_decode

// ---- rtl/spp_lane_pick.sv ----
// Per-lane two-way selector steered by one select bit per lane.
// Assumes both sources and the result share lane count and width.
`timescale 1ns/100ps
module spp_lane_pick #(
   parameter int unsigned LANES = 8,
   parameter int unsigned LANE_W = 8
) (
   input wire logic [LANES*LANE_W-1:0] first_in,
   input wire logic [LANES*LANE_W-1:0] second_in,
   input wire logic [LANES-1:0] sel_in,
   output logic [LANES*LANE_W-1:0] pick_out
);

   // A set select bit takes the lane from the first source.
   for (genvar i = 0; i < LANES; i++) begin : g_lane
      assign pick_out[i*LANE_W +: LANE_W] = sel_in[i] ?
         first_in[i*LANE_W +: LANE_W] : second_in[i*LANE_W +: LANE_W];
   end

endmodule : spp_lane_pick

// ---- verif/spp_pipe_model.sv ----
// Pipeline-side model: a register file that feeds the unit's sources by
// index and takes its write-backs.
// Assumes the unit's index outputs settle combinationally within the cycle.
`timescale 1ns/100ps
module spp_pipe_model
   import spp_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic [IDX_W-1:0] first_idx_in,
   input wire logic [IDX_W-1:0] second_idx_in,
   input wire logic wr_en_in,
   input wire logic [IDX_W-1:0] dest_idx_in,
   input wire logic [DATA_W-1:0] dest_data_in,
   output logic [DATA_W-1:0] first_source_out,
   output logic [DATA_W-1:0] second_source_out
);
   // -----------------------------------------------------------------
   // Register file
   // -----------------------------------------------------------------
   logic [DATA_W-1:0] regs [32];

   // Reads follow the index fields at once, so a wrong field slice shows.
   assign first_source_out = regs[first_idx_in];
   assign second_source_out = regs[second_idx_in];

   // Write-back lands on the edge that sees the write pulse.
   always @(posedge core_clk_in) begin
      if (wr_en_in === 1'b1) begin
         regs[dest_idx_in] <= dest_data_in;
      end
   end

   // Preload used by the bench before reset is released.
   task automatic load(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] val);
      regs[idx] = val;
   endtask : load
endmodule : spp_pipe_model

// ---- verif/tb.sv ----
// Self-checking bench for the pack and condition-select unit.
// Assumes the pipeline model supplies sources by index and keeps results.
`timescale 1ns/100ps
module tb
   import spp_pkg::*;
;
   localparam logic [63:0] VA = 64'hF0E1_D2C3_B4A5_9687;
   localparam logic [63:0] VB = 64'h0F1E_2D3C_4B5A_6978;
   logic core_clk_in;
   logic rst_n_in = 1'b0;
   logic ce_in = 1'b1;
   logic issue_in = 1'b0;
   logic [INSTR_W-1:0] instr_in = 32'h0000_0000;
   logic [CTRL_W-1:0] ctrl = 32'h0000_0000;
   logic ext_en = 1'b1;
   logic [IDX_W-1:0] ia, ib, di;
   logic [DATA_W-1:0] sa, sb, dd;
   logic wr, rexc, dexc;
   spp_op_t op;
   logic [63:0] last_exp = 64'h0;
   int failures = 0;
   int checks_done = 0;

   // -----------------------------------------------------------------
   // Clock, design and partner
   // -----------------------------------------------------------------
   initial begin
      core_clk_in = 1'b0;
      forever #4 core_clk_in = ~core_clk_in;
   end

   spp_unit i_spp_unit (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
      .issue_in(issue_in), .instr_in(instr_in), .first_source_in(sa),
      .second_source_in(sb), .signal_ext_control_reg_in(ctrl), .ext_enable_in(ext_en),
      .first_source_idx_out(ia), .second_source_idx_out(ib), .wr_en_out(wr),
      .dest_idx_out(di), .dest_data_out(dd), .op_out(op), .reserved_exc_out(rexc),
      .disabled_exc_out(dexc));

   spp_pipe_model i_spp_pipe_model (.core_clk_in(core_clk_in), .first_idx_in(ia),
      .second_idx_in(ib), .wr_en_in(wr), .dest_idx_in(di), .dest_data_in(dd),
      .first_source_out(sa), .second_source_out(sb));

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   function automatic logic [31:0] mk(input logic [4:0] sub, input logic [5:0] fn);
      mk = {OPC_MAJOR_GROUP_THREE, 5'h03, 5'h07, 5'h09, sub, fn};
   endfunction : mk

   // Lane-wise choice: lane of width lw comes from a when its select bit is set.
   function automatic logic [63:0] pick(input logic [63:0] a, input logic [63:0] b,
                                        input logic [7:0] s, input int lw);
      for (int i = 0; i < 64; i++) pick[i] = s[i / lw] ? a[i] : b[i];
   endfunction : pick

   function automatic logic [63:0] sext(input logic [63:0] x);
      sext = {{32{x[31]}}, x[31:0]};
   endfunction : sext

   // One issue cycle; outputs are looked at once the answering edge has landed.
   task automatic run(input logic [31:0] ins, input logic [7:0] cc, input logic en);
      @(posedge core_clk_in);
      instr_in <= ins;
      ctrl <= {cc, 24'h5A_A5C3};
      ext_en <= en;
      issue_in <= 1'b1;
      @(posedge core_clk_in);
      issue_in <= 1'b0;
      #1;
   endtask : run

   task automatic do_op(input logic [4:0] sub, input logic [5:0] fn, input logic [7:0] cc,
                        input spp_op_t eop, input logic [63:0] ed);
      run(mk(sub, fn), cc, 1'b1);
      chk("wr_en", 64'h1, {63'h0, wr});
      chk("exc", 64'h0, {62'h0, rexc, dexc});
      chk("data", ed, dd);
      chk("dest", 64'h9, {59'h0, di});
      chk("op", {61'h0, eop}, {61'h0, op});
      last_exp = ed;
   endtask : do_op

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_pack;
      do_op(SUB_PACK_CROSS, FN_GROUP_QUAD_BYTE, 8'hFF, SPP_OP_PACK_CROSS_HALFWORDS,
            sext({32'h0, VA[15:0], VB[31:16]}));
      @(posedge core_clk_in);
      #1;
      chk("wr_en drop", 64'h0, {63'h0, wr});
      do_op(SUB_PACK_CROSS, FN_GROUP_OCTAL_BYTE, 8'h00, SPP_OP_PACK_CROSS_WORDS,
            {VA[31:0], VB[63:32]});
   endtask : t_pack

   // Two condition patterns so each lane is seen from both sources.
   task automatic t_select;
      logic [7:0] cc;
      for (int k = 0; k < 2; k++) begin
         cc = (k == 0) ? 8'hA5 : 8'h5A;
         do_op(SUB_SELECT_BYTES, FN_GROUP_OCTAL_BYTE, cc, SPP_OP_SELECT_EIGHT_BYTES,
               pick(VA, VB, cc, 8));
         do_op(SUB_SELECT_HALVES, FN_GROUP_QUAD_BYTE, cc, SPP_OP_SELECT_TWO_HALFWORDS,
               sext(pick(VA, VB, {6'h0, cc[1:0]}, 16)));
         do_op(SUB_SELECT_WORDS, FN_GROUP_OCTAL_BYTE, cc, SPP_OP_SELECT_TWO_WORDS,
               pick(VA, VB, cc, 32));
         do_op(SUB_SELECT_BYTES, FN_GROUP_QUAD_BYTE, cc, SPP_OP_SELECT_FOUR_BYTES,
               sext(pick(VA, VB, {4'h0, cc[3:0]}, 8)));
      end
   endtask : t_select

   // Unknown encodings, a foreign opcode and a disabled extension never write.
   task automatic t_refuse;
      run(mk(SUB_PACK_CROSS, 6'h16), 8'hFF, 1'b1);
      chk("rsv fn", 64'h2, {62'h0, rexc, wr});
      run({6'h00, 26'(mk(SUB_PACK_CROSS, FN_GROUP_QUAD_BYTE))}, 8'hFF, 1'b1);
      chk("rsv opc", 64'h2, {62'h0, rexc, wr});
      run(mk(SUB_SELECT_WORDS, FN_GROUP_QUAD_BYTE), 8'hFF, 1'b0);
      chk("rsv prio", 64'h4, {61'h0, rexc, dexc, wr});
      run(mk(SUB_SELECT_WORDS, FN_GROUP_OCTAL_BYTE), 8'hFF, 1'b0);
      chk("disabled", 64'h2, {61'h0, rexc, dexc, wr});
      chk("data kept", last_exp, dd);
   endtask : t_refuse

   // An issue while the clock enable is low is ignored.
   task automatic t_ce_low;
      @(posedge core_clk_in);
      ce_in <= 1'b0;
      run(mk(SUB_PACK_CROSS, FN_GROUP_OCTAL_BYTE), 8'h00, 1'b1);
      chk("ce wr", 64'h0, {63'h0, wr});
      chk("ce data", last_exp, dd);
      @(posedge core_clk_in);
      ce_in <= 1'b1;
   endtask : t_ce_low

   // A reset in mid-run clears the held result; the next issue is taken at once.
   task automatic t_reset;
      run(mk(SUB_PACK_CROSS, FN_GROUP_OCTAL_BYTE), 8'h00, 1'b1);
      chk("pre rst wr", 64'h1, {63'h0, wr});
      @(posedge core_clk_in);
      rst_n_in <= 1'b0;
      @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      #1;
      chk("rst mid data", 64'h0, dd);
      chk("rst mid op", 64'h0, {61'h0, op});
      chk("rst mid dest", 64'h0, {59'h0, di});
      do_op(SUB_PACK_CROSS, FN_GROUP_OCTAL_BYTE, 8'h00, SPP_OP_PACK_CROSS_WORDS,
            {VA[31:0], VB[63:32]});
   endtask : t_reset

   task automatic end_sim;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim

   // -----------------------------------------------------------------
   // Main sequence and watchdog
   // -----------------------------------------------------------------
   initial begin
      i_spp_pipe_model.load(5'h03, VA);
      i_spp_pipe_model.load(5'h07, VB);
      repeat (20) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      #1;
      chk("rst data", 64'h0, dd);
      chk("rst flags", 64'h0, {61'h0, wr, rexc, dexc});
      t_pack();
      t_select();
      t_refuse();
      t_ce_low();
      t_reset();
      end_sim();
   end

   // The sequence needs under a hundred cycles; this span is far beyond that.
   initial begin
      #20000;
      failures++;
      end_sim();
   end
endmodule : tb
